/* File: pkg/bsc_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef BSC_REGS_SVH
`define BSC_REGS_SVH

// ********************************
// Register map (byte addresses)
// ********************************
`define BSC_CTRL_OFS        4'h0
`define BSC_FREQ_OFS        4'h4
`define BSC_CFG_OFS         4'h8
`define BSC_STAT_OFS        4'hc

// ********************************
// Field positions
// ********************************
`define BSC_CTRL_REQ_BIT    0
`define BSC_CTRL_VREG_BIT   1
`define BSC_FREQ_SEL_LSB    0
`define BSC_FREQ_TRIM_LSB   4
`define BSC_CFG_PEAK_LSB    0
`define BSC_CFG_LOW_LSB     4
`define BSC_CFG_HIGH_LSB    8

// ********************************
// Reset values
// ********************************
`define BSC_CTRL_RST        32'h0000_0002
`define BSC_FREQ_RST        32'h0000_0000
`define BSC_CFG_RST         32'h0000_0000

// ********************************
// Timing
// ********************************
`define BSC_CLK_HZ          50000000
`define BSC_REFRESH_NS      5000
`define BSC_HIGH_ON_NS      80
`define BSC_LOW_ON_NS       160
`define BSC_REFRESH_COUNT   32
`define BSC_SYNC_LOSS       1024
`define BSC_REFRESH_CYC     ((`BSC_REFRESH_NS * 50 + 999) / 1000)
`define BSC_HIGH_CYC        ((`BSC_HIGH_ON_NS * 50 + 999) / 1000)
`define BSC_LOW_CYC         ((`BSC_LOW_ON_NS * 50 + 999) / 1000)

`endif

/* File: pkg/bsc_pkg.sv */
// Types shared by the bridge switching control block
package bsc_pkg;

  typedef enum logic [1:0] {
    BSC_IDLE   = 2'b00,
    BSC_REFRESH = 2'b01,
    BSC_RUN    = 2'b10
  } bsc_state_t;

  typedef enum logic [1:0] {
    BSC_PH_HIGH = 2'b00,
    BSC_PH_LOW  = 2'b01,
    BSC_PH_OFF  = 2'b10
  } bsc_phase_t;

endpackage

/* File: logic/bsc_switch_ctrl.sv */
// Switching stage control: frequency, sync, bootstrap refresh, settings
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bsc_regs.svh"

module bsc_switch_ctrl #(
  parameter int REFRESH_CYC   = `BSC_REFRESH_CYC,
  parameter int REFRESH_COUNT = `BSC_REFRESH_COUNT
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        switching_enable_pin,
  input  wire logic        fault,
  output logic             switching_enable_pin_oe,
  output logic             switching_enable_pin_o,
  input  wire logic        sync_in,
  output logic             sync_active,
  output logic [2:0]       eff_freq_select,
  output logic [1:0]       eff_freq_trim,
  output logic             buck_high_switch,
  output logic             buck_low_switch,
  output logic             pwm_run,
  output logic             core_reg_target_sel,
  output logic [2:0]       init_peak_current_code,
  output logic [3:0]       lin_low_power_cap,
  output logic [3:0]       lin_high_power_cap
);

  localparam int SYNC_LOSS = `BSC_SYNC_LOSS;

  // ********************************
  // Register bus
  // ********************************
  logic [31:0] ctrl_r, ctrl_nxt, freq_r, freq_nxt, cfg_r, cfg_nxt;
  logic        aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [3:0]  awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0]  wstrb_r, wstrb_nxt;
  logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        en_q_r;
  logic        pin_m_r, pin_s_r, sync_m_r, sync_s_r, sync_d_r;
  logic [10:0] sync_cnt_r, sync_cnt_nxt;
  logic        sync_act_r, sync_act_nxt;
  logic        sw_enabled;
  bsc_pkg::bsc_state_t st_r, st_nxt;
  logic [12:0] cyc_r, cyc_nxt;
  logic [5:0]  refresh_idx_r, refresh_idx_nxt;
  logic        hi_nxt, lo_nxt, hi_r, lo_r;

  function automatic logic mapped(input logic [3:0] a);
    mapped = (a == `BSC_CTRL_OFS) || (a == `BSC_FREQ_OFS) ||
             (a == `BSC_CFG_OFS) || (a == `BSC_STAT_OFS);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    merge = m;
  endfunction

  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready  = !w_hold_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_comb begin
    aw_hold_nxt = aw_hold_r;
    w_hold_nxt  = w_hold_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    ctrl_nxt    = ctrl_r;
    freq_nxt    = freq_r;
    cfg_nxt     = cfg_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_nxt = 1'b1;
      awaddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
    end
    if (aw_hold_nxt && w_hold_nxt && !bvalid_r) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = mapped(awaddr_nxt) ? 2'h0 : 2'h2;
      unique case (awaddr_nxt)
        `BSC_CTRL_OFS: ctrl_nxt = merge(ctrl_r, wdata_nxt, wstrb_nxt) &
                                  32'h0000_0003;
        `BSC_FREQ_OFS: freq_nxt = merge(freq_r, wdata_nxt, wstrb_nxt) &
                                  32'h0000_0037;
        `BSC_CFG_OFS:  cfg_nxt  = merge(cfg_r, wdata_nxt, wstrb_nxt) &
                                  32'h0000_0fff;
        default: ;
      endcase
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    // Fault or pin drop clears the request so re-enable is deliberate
    if (en_q_r && !sw_enabled) begin
      ctrl_nxt[`BSC_CTRL_REQ_BIT] = 1'b0;
    end
  end

  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = mapped(s_axi_araddr) ? 2'h0 : 2'h2;
      unique case (s_axi_araddr)
        `BSC_CTRL_OFS: rdata_nxt = ctrl_r;
        `BSC_FREQ_OFS: rdata_nxt = freq_r;
        `BSC_CFG_OFS:  rdata_nxt = cfg_r;
        `BSC_STAT_OFS: rdata_nxt = {27'h0, st_r == bsc_pkg::BSC_RUN,
                                    st_r == bsc_pkg::BSC_REFRESH,
                                    sync_active, pin_s_r, sw_enabled};
        default:       rdata_nxt = 32'h0;
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // ********************************
  // Pin synchronisers and sync detect
  // ********************************
  // Request and pin together enable switching; fault pulls the pin low and forces the enable off
  assign sw_enabled = pin_s_r && ctrl_r[`BSC_CTRL_REQ_BIT] && !fault;
  assign switching_enable_pin_oe = fault;
  assign switching_enable_pin_o  = 1'b0;

  // Rising edges keep sync alive; a long quiet spell falls back to oscillator
  always_comb begin
    sync_cnt_nxt = sync_cnt_r;
    sync_act_nxt = sync_act_r;
    if (sync_s_r && !sync_d_r) begin
      sync_cnt_nxt = 11'h0;
      sync_act_nxt = 1'b1;
    end else if (sync_cnt_r == 11'(SYNC_LOSS)) begin
      sync_act_nxt = 1'b0;
    end else begin
      sync_cnt_nxt = sync_cnt_r + 11'h1;
    end
  end

  assign sync_active = sync_act_r;

  // ********************************
  // Bootstrap refresh sequencer
  // ********************************
  always_comb begin
    st_nxt          = st_r;
    cyc_nxt         = cyc_r;
    refresh_idx_nxt = refresh_idx_r;
    hi_nxt          = 1'b0;
    lo_nxt          = 1'b0;
    unique case (st_r)
      bsc_pkg::BSC_IDLE: begin
        if (sw_enabled) begin
          st_nxt          = bsc_pkg::BSC_REFRESH;
          cyc_nxt         = 13'h0;
          refresh_idx_nxt = 6'h0;
          hi_nxt          = 1'b1;
        end
      end
      bsc_pkg::BSC_REFRESH: begin
        if (cyc_r == 13'(REFRESH_CYC - 1)) begin
          cyc_nxt         = 13'h0;
          refresh_idx_nxt = refresh_idx_r + 6'h1;
          if (refresh_idx_r == 6'(REFRESH_COUNT - 1)) begin
            st_nxt = bsc_pkg::BSC_RUN;
          end else begin
            hi_nxt = 1'b1;
          end
        end else begin
          cyc_nxt = cyc_r + 13'h1;
          // High first, then low, then both off
          hi_nxt = (cyc_r + 13'h1) < 13'(`BSC_HIGH_CYC);
          lo_nxt = ((cyc_r + 13'h1) >= 13'(`BSC_HIGH_CYC)) &&
                   ((cyc_r + 13'h1) <
                    13'(`BSC_HIGH_CYC + `BSC_LOW_CYC));
        end
      end
      bsc_pkg::BSC_RUN: ;
      default: st_nxt = bsc_pkg::BSC_IDLE;
    endcase
    if (!sw_enabled) begin
      st_nxt = bsc_pkg::BSC_IDLE;
      hi_nxt = 1'b0;
      lo_nxt = 1'b0;
    end
  end

  assign buck_high_switch = hi_r;
  assign buck_low_switch  = lo_r;
  assign pwm_run          = (st_r == bsc_pkg::BSC_RUN);

  // ********************************
  // Settings decode
  // ********************************
  always_comb begin
    eff_freq_select = freq_r[`BSC_FREQ_SEL_LSB +: 3];
    eff_freq_trim   = freq_r[`BSC_FREQ_TRIM_LSB +: 2];
    if (eff_freq_select > 3'h5) begin
      eff_freq_select = 3'h5;
    end
    if (eff_freq_trim == 2'h3) begin
      eff_freq_trim = 2'h0;
    end
  end

  assign core_reg_target_sel    = ctrl_r[`BSC_CTRL_VREG_BIT];
  assign init_peak_current_code = cfg_r[`BSC_CFG_PEAK_LSB +: 3];
  assign lin_low_power_cap      = cfg_r[`BSC_CFG_LOW_LSB +: 4];
  assign lin_high_power_cap     = cfg_r[`BSC_CFG_HIGH_LSB +: 4];

  // ********************************
  // Registers
  // ********************************
  always_ff @(posedge aclk) begin
    pin_m_r  <= switching_enable_pin;
    pin_s_r  <= pin_m_r;
    sync_m_r <= sync_in;
    sync_s_r <= sync_m_r;
    sync_d_r <= sync_s_r;
    if (!aresetn) begin
      ctrl_r        <= `BSC_CTRL_RST;
      freq_r        <= `BSC_FREQ_RST;
      cfg_r         <= `BSC_CFG_RST;
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      awaddr_r      <= 4'h0;
      wdata_r       <= 32'h0;
      wstrb_r       <= 4'h0;
      bvalid_r      <= 1'b0;
      bresp_r       <= 2'h0;
      rvalid_r      <= 1'b0;
      rdata_r       <= 32'h0;
      rresp_r       <= 2'h0;
      sync_cnt_r    <= 11'h0;
      sync_act_r    <= 1'b0;
      st_r          <= bsc_pkg::BSC_IDLE;
      cyc_r         <= 13'h0;
      refresh_idx_r <= 6'h0;
      hi_r          <= 1'b0;
      lo_r          <= 1'b0;
      en_q_r        <= 1'b0;
    end else begin
      ctrl_r        <= ctrl_nxt;
      freq_r        <= freq_nxt;
      cfg_r         <= cfg_nxt;
      aw_hold_r     <= aw_hold_nxt;
      w_hold_r      <= w_hold_nxt;
      awaddr_r      <= awaddr_nxt;
      wdata_r       <= wdata_nxt;
      wstrb_r       <= wstrb_nxt;
      bvalid_r      <= bvalid_nxt;
      bresp_r       <= bresp_nxt;
      rvalid_r      <= rvalid_nxt;
      rdata_r       <= rdata_nxt;
      rresp_r       <= rresp_nxt;
      sync_cnt_r    <= sync_cnt_nxt;
      sync_act_r    <= sync_act_nxt;
      st_r          <= st_nxt;
      cyc_r         <= cyc_nxt;
      refresh_idx_r <= refresh_idx_nxt;
      hi_r          <= hi_nxt;
      lo_r          <= lo_nxt;
      en_q_r        <= sw_enabled;
    end
  end

endmodule // bsc_switch_ctrl

`default_nettype wire

/* File: testbench/bsc_switch_ctrl_asserts.sv */
// Checker for refresh timing, decode folding and enable gating
`timescale 1ns/1ps
`default_nettype none
module bsc_switch_ctrl_chk #(
  parameter int REFRESH_COUNT = 32
) (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       switching_enable_pin,
  input wire logic       fault,
  input wire logic       switching_enable_pin_oe,
  input wire logic       sync_in,
  input wire logic       sync_active,
  input wire logic [2:0] eff_freq_select,
  input wire logic [1:0] eff_freq_trim,
  input wire logic       buck_high_switch,
  input wire logic       buck_low_switch,
  input wire logic       pwm_run
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************
  // Refresh counting
  // ****************
  logic [7:0] rises_r, rises_nxt;
  logic       hi_d_r;
  always_comb begin
    rises_nxt = rises_r;
    if (pwm_run || fault || !switching_enable_pin) rises_nxt = 8'h00;
    else if (buck_high_switch && !hi_d_r) rises_nxt = rises_r + 8'h01;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rises_r <= 8'h00;
      hi_d_r  <= 1'b0;
    end else begin
      rises_r <= rises_nxt;
      hi_d_r  <= buck_high_switch;
    end
  end
  sequence s_high_on;
    (buck_high_switch && !buck_low_switch) [*4];
  endsequence
  sequence s_low_on;
    (!buck_high_switch && buck_low_switch) [*8];
  endsequence
  property p_sel_fold; eff_freq_select <= 3'h5; endproperty
  property p_trim_fold; eff_freq_trim != 2'h3; endproperty
  // Enable loss cuts a refresh short, so it silences this one
  property p_refresh_shape;
    disable iff (!aresetn || fault || !switching_enable_pin)
    $rose(buck_high_switch) |-> s_high_on ##1 s_low_on ##1 !buck_low_switch;
  endproperty
  property p_run_quiet;
    pwm_run |-> !buck_high_switch && !buck_low_switch;
  endproperty
  property p_run_count;
    $rose(pwm_run) |-> rises_r == 8'(REFRESH_COUNT);
  endproperty
  property p_fault_stops;
    fault |-> switching_enable_pin_oe ##1 (!pwm_run && !buck_high_switch);
  endproperty
  property p_pin_stops;
    !switching_enable_pin [*4] |=> !pwm_run && !buck_high_switch;
  endproperty
  property p_sync_seen; $rose(sync_in) |-> ##[1:8] sync_active; endproperty
  a_sel_fold: assert property (p_sel_fold)
    else $error("frequency select not folded");
  a_trim_fold: assert property (p_trim_fold)
    else $error("frequency trim not folded");
  a_refresh_shape: assert property (p_refresh_shape)
    else $error("refresh pulse shape wrong");
  a_run_quiet: assert property (p_run_quiet)
    else $error("refresh gates active while running");
  a_run_count: assert property (p_run_count)
    else $error("running began after wrong refresh count");
  a_fault_stops: assert property (p_fault_stops)
    else $error("fault did not stop switching");
  a_pin_stops: assert property (p_pin_stops)
    else $error("low enable pin did not stop switching");
  a_sync_seen: assert property (p_sync_seen)
    else $error("sync clock not detected");
endmodule // bsc_switch_ctrl_chk
bind bsc_switch_ctrl bsc_switch_ctrl_chk #(.REFRESH_COUNT(REFRESH_COUNT)) u_chk (
  .aclk, .aresetn, .switching_enable_pin, .fault, .switching_enable_pin_oe,
  .sync_in, .sync_active, .eff_freq_select, .eff_freq_trim,
  .buck_high_switch, .buck_low_switch, .pwm_run);
`default_nettype wire

/* File: testbench/bsc_switch_ctrl_tb_top.sv */
// Self-checking bench for the bridge switching control block
`timescale 1ns/1ps
`default_nettype none
`include "bsc_regs.svh"
module bsc_switch_ctrl_tb_top;
  localparam int RCYC = 20;
  localparam int RCNT = 4;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, pin_drv, fault;
  logic        switching_enable_pin_oe, switching_enable_pin_o, sync_in;
  logic        sync_active, buck_high_switch, buck_low_switch, pwm_run;
  logic        core_reg_target_sel;
  logic [1:0]  s_axi_bresp, s_axi_rresp, eff_freq_trim, resp;
  logic [2:0]  eff_freq_select, init_peak_current_code;
  logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [3:0]  lin_low_power_cap, lin_high_power_cap;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  int          num_errors, checks;
  // Open-drain wire: the block pulls low while its enable is high
  wire switching_enable_pin = pin_drv & ~switching_enable_pin_oe;
  bsc_switch_ctrl #(.REFRESH_CYC(RCYC), .REFRESH_COUNT(RCNT)) i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .switching_enable_pin, .fault, .switching_enable_pin_oe,
    .switching_enable_pin_o, .sync_in, .sync_active, .eff_freq_select,
    .eff_freq_trim, .buck_high_switch, .buck_low_switch, .pwm_run,
    .core_reg_target_sel, .init_peak_current_code, .lin_low_power_cap,
    .lin_high_power_cap);
  // ********************
  // Bus and check tasks
  // ********************
  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic chk_refresh();
    int         n;
    int         ph;
    logic [2:0] ex;
    logic [2:0] sn;
    n = 0;
    // Called on an edge: look once the design's registers have settled
    #1;
    while (buck_high_switch !== 1'b1 && n < 20) begin
      @(posedge aclk);
      #1 n++;
    end
    for (int i = 0; i < RCNT * RCYC; i++) begin
      ph = i % RCYC;
      ex = {ph < 4, ph >= 4 && ph < 12, 1'b0};
      sn = {buck_high_switch, buck_low_switch, pwm_run};
      chk("refresh", 32'(sn), 32'(ex));
      @(posedge aclk);
      #1;
    end
    chk("run", 32'(pwm_run), 32'h1);
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_settings();
    logic [31:0] d;
    logic [3:0]  lo;
    axi_rd(`BSC_CTRL_OFS, d);
    chk("ctrl", d, `BSC_CTRL_RST);
    chk("rd ok", 32'(resp), 32'h0);
    for (int s = 0; s < 8; s++)
      for (int t = 0; t < 4; t++) begin
        axi_wr(`BSC_FREQ_OFS, 32'(t * 16 + s));
        chk("sel", 32'(eff_freq_select), s > 5 ? 32'h5 : 32'(s));
        chk("trim", 32'(eff_freq_trim), t == 3 ? 32'h0 : 32'(t));
      end
    for (int k = 0; k < 8; k++) begin
      lo = 4'(k * 5);
      axi_wr(`BSC_CFG_OFS, {20'h0, ~lo, lo, 1'b0, 3'(k)});
      chk("peak", 32'(init_peak_current_code), 32'(k));
      chk("high cap", 32'(lin_high_power_cap), 32'({~lo}));
      chk("low cap", 32'(lin_low_power_cap), 32'(lo));
      axi_wr(`BSC_CTRL_OFS, 32'(k % 2) << 1);
      chk("vreg", 32'(core_reg_target_sel), 32'(k % 2));
    end
    // Only byte lane 0 written: peak and low cap change, high cap stays
    s_axi_wstrb <= 4'h1;
    axi_wr(`BSC_CFG_OFS, 32'hffff_ff05);
    s_axi_wstrb <= 4'hf;
    chk("lane peak", 32'(init_peak_current_code), 32'h5);
    chk("lane low", 32'(lin_low_power_cap), 32'h0);
    chk("lane high", 32'(lin_high_power_cap), 32'hc);
    axi_wr(4'h2, 32'hffff_ffff);
    chk("wr resp", 32'(resp), 32'h2);
    chk("no alias", 32'(core_reg_target_sel), 32'h1);
    axi_rd(4'h2, d);
    chk("rd resp", 32'(resp), 32'h2);
    chk("rd data", d, 32'h0);
    $display("settings test ended");
  endtask
  task automatic t_enable();
    logic [31:0] d;
    axi_wr(`BSC_CTRL_OFS, 32'h3);
    chk_refresh();
    axi_rd(`BSC_STAT_OFS, d);
    chk("status", d, 32'h13);
    @(posedge aclk);
    fault <= 1'b1;
    #1 chk("pull oe", 32'(switching_enable_pin_oe), 32'h1);
    chk("pull level", 32'(switching_enable_pin_o), 32'h0);
    @(posedge aclk);
    fault <= 1'b0;
    #1 chk("fault", 32'({pwm_run, buck_high_switch}), 32'h0);
    chk("released", 32'(switching_enable_pin_oe), 32'h0);
    axi_rd(`BSC_CTRL_OFS, d);
    chk("req cleared", d, 32'h2);
    axi_wr(`BSC_CTRL_OFS, 32'h3);
    chk_refresh();
    @(posedge aclk);
    pin_drv <= 1'b0;
    // Let the pin drop clear the request before asking again
    repeat (4) @(posedge aclk);
    axi_wr(`BSC_CTRL_OFS, 32'h3);
    repeat (10) @(posedge aclk);
    #1 chk("pin low", 32'({pwm_run, buck_high_switch}), 32'h0);
    @(posedge aclk);
    pin_drv <= 1'b1;
    chk_refresh();
    $display("enable test ended");
  endtask
  task automatic t_sync();
    @(posedge aclk);
    repeat (6) begin
      sync_in <= 1'b1; // High time 30 percent
      repeat (3) @(posedge aclk);
      sync_in <= 1'b0; // Ten-clock period, above the floor
      repeat (7) @(posedge aclk);
    end
    #1 chk("sync on", 32'(sync_active), 32'h1);
    repeat (1100) @(posedge aclk);
    #1 chk("sync off", 32'(sync_active), 32'h0);
    $display("sync test ended");
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    repeat (30000) @(posedge aclk);
    num_errors++;
    conclude();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, fault, sync_in} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    s_axi_wstrb = 4'hf;
    pin_drv = 1'b1;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_settings();
    t_enable();
    t_sync();
    conclude();
  end
endmodule // bsc_switch_ctrl_tb_top
`default_nettype wire
